// [rtl/irpwm_pkg.sv]
// package: constants and carrier types of the infrared pulse-width mode host controller
package irpwm_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  // least times round up, longest times round down
  localparam int T_SETUP_NS = 200;
  localparam int T_HOLD_NS = 200;
  localparam int T_PROG_MAX_US = 600;
  localparam int T_LONG_SD_US = 1500;
  localparam int T_TX_MAX_US = 80;
  localparam int T_PULSE_SHORT_NS = 400;
  localparam int T_PULSE_LONG_NS = 2000;
  localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PROG_MAX_CYC = (T_PROG_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int LONG_SD_CYC = (T_LONG_SD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TX_MAX_CYC = (T_TX_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int SHORT_PULSE_CYC = (T_PULSE_SHORT_NS * 1000) / CLK_PERIOD_PS;
  localparam int LONG_PULSE_CYC = (T_PULSE_LONG_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 18;
  localparam logic MODE_SHORT = 1'b0;
  localparam logic MODE_LONG = 1'b1;

  typedef enum logic [1:0]
  {
    IRPWM_CMD_NONE,
    IRPWM_CMD_SET_LONG,
    IRPWM_CMD_SET_SHORT,
    IRPWM_CMD_SHUTDOWN
  } irpwm_cmd_t;

  // pins toward the transceiver
  typedef struct packed
  {
    logic shutdown_input;
    logic tx_data;
  } irpwm_pins_t;
endpackage

// [rtl/irpwm_sync.sv]
// two-flop synchroniser for the receive pin
`timescale 1ns/100ps
module irpwm_sync
  import irpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  // rx idles high (pull-up), so reset to high avoids a false edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// [rtl/irpwm_host.sv]
// host controller: programs the receive pulse mode and gates transmit data
`timescale 1ns/100ps
// What this block does
// RULE_01 - device powers up in short receive-pulse mode; host mirrors that
// RULE_02 - shutdown held over 1.5 ms resets device to short mode
// RULE_03 - long mode: shutdown high, tx high, wait 200 ns, drop shutdown
// RULE_04 - hold tx level 200 ns after falling shutdown edge, then normal data
// RULE_05 - tx low at latching edge returns device to short 400 ns pulses
// RULE_06 - whole programming sequence finishes within 600 us
// RULE_07 - short shutdown pulse with tx low selects short pulse mode
// RULE_08 - while shutdown high, emitter off and receive output only pulled up
// RULE_09 - emitter cut after 80 us tx high; host limits tx-high holds
// RULE_10 - weak optical input leaves receive output idle high
// RULE_11 - receive low only when shutdown and tx low; ignored while sending
// RULE_12 - latched mode retained until reprogrammed or long shutdown
module irpwm_host
  import irpwm_pkg::*;
#(
  parameter int LONG_SD_CYCLES = LONG_SD_CYC,
  parameter int PROG_MAX_CYCLES = PROG_MAX_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire irpwm_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic user_tx,
  output logic user_rx_pulse,
  output logic mode_long,
  output logic prog_error,
  output irpwm_pins_t pins,
  input wire logic rx_pin_n
);
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_SETUP,
    ST_HOLD,
    ST_LONG_SD
  } irpwm_state_t;

  irpwm_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] tx_hi_reg;
  logic [CNT_W-1:0] prog_cnt_reg;
  logic target_reg;
  logic mode_reg;
  logic sd_reg;
  logic txd_reg;
  logic err_reg;
  logic rx_sync;
  logic rx_d_reg;
  logic rx_pulse_reg;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  irpwm_sync u_rx_sync
  (
    .clk(clk),
    .rst(rst),
    .async_in(rx_pin_n),
    .sync_out(rx_sync)
  );

  assign cmd_ready = (state_reg == ST_IDLE);
  assign pins = '{shutdown_input: sd_reg, tx_data: txd_reg};
  assign mode_long = mode_reg;
  assign prog_error = err_reg;
  assign user_rx_pulse = rx_pulse_reg;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      target_reg <= MODE_SHORT;
      sd_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cnt_reg <= '0;
          if (cmd_valid && cmd == IRPWM_CMD_SET_LONG)
          begin
            target_reg <= MODE_LONG; // RULE_03
            sd_reg <= 1'b1;
            state_reg <= ST_SETUP;
          end
          else if (cmd_valid && cmd == IRPWM_CMD_SET_SHORT)
          begin
            target_reg <= MODE_SHORT; // RULE_05
            sd_reg <= 1'b1;
            state_reg <= ST_SETUP;
          end
          else if (cmd_valid && cmd == IRPWM_CMD_SHUTDOWN)
          begin
            sd_reg <= 1'b1; // RULE_02
            state_reg <= ST_LONG_SD;
          end
        end
        ST_SETUP:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg >= cyc(SETUP_CYC))
          begin
            sd_reg <= 1'b0; // RULE_03
            cnt_reg <= '0;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg >= cyc(HOLD_CYC))
            state_reg <= ST_IDLE; // RULE_04
        end
        ST_LONG_SD:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg >= cyc(LONG_SD_CYCLES))
          begin
            sd_reg <= 1'b0; // RULE_02
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          sd_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // tracked device mode
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_reg <= MODE_SHORT; // RULE_01
    // every short pulse carries the wanted tx level, so the bare-pulse route never applies
    else if (state_reg == ST_SETUP && cnt_reg >= cyc(SETUP_CYC))
      mode_reg <= target_reg; // RULE_12 RULE_07
    else if (state_reg == ST_LONG_SD && cnt_reg >= cyc(LONG_SD_CYCLES))
      mode_reg <= MODE_SHORT; // RULE_02
  end

  // ----------------------------------------
  // programming window watchdog
  // ----------------------------------------
  // sticky until reset: an overrun means the device state is uncertain
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prog_cnt_reg <= '0;
      err_reg <= 1'b0;
    end
    else if (state_reg == ST_SETUP)
    begin
      prog_cnt_reg <= prog_cnt_reg + 1'b1;
      if (prog_cnt_reg >= cyc(PROG_MAX_CYCLES))
        err_reg <= 1'b1; // RULE_06
    end
    else
      prog_cnt_reg <= '0;
  end

  // ----------------------------------------
  // transmit pin
  // ----------------------------------------
  // the level during setup and hold is the target mode bit (target_reg), not user data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txd_reg <= 1'b0;
      tx_hi_reg <= '0;
    end
    else if (state_reg == ST_SETUP || state_reg == ST_HOLD)
    begin
      txd_reg <= target_reg; // RULE_04
      // a high programming level counts toward the emitter limit as well
      tx_hi_reg <= target_reg ? tx_hi_reg + 1'b1 : '0; // RULE_09
    end
    else if (state_reg == ST_LONG_SD)
    begin
      txd_reg <= 1'b0; // RULE_08
      tx_hi_reg <= '0;
    end
    else if (user_tx && tx_hi_reg < cyc(TX_MAX_CYC))
    begin
      txd_reg <= 1'b1;
      tx_hi_reg <= tx_hi_reg + 1'b1;
    end
    else
    begin
      txd_reg <= 1'b0; // RULE_09
      if (!user_tx)
        tx_hi_reg <= '0;
    end
  end

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  // one pulse per falling edge; ignored while shut down or sending (echo)
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_d_reg <= 1'b1;
      rx_pulse_reg <= 1'b0;
    end
    else
    begin
      rx_d_reg <= rx_sync;
      rx_pulse_reg <= rx_d_reg && !rx_sync && !sd_reg && !txd_reg
        && state_reg == ST_IDLE; // RULE_11 RULE_10 RULE_08
    end
  end
endmodule

// [verification/irpwm_checker.sv]
// assertion checker of the infrared pulse-width mode host controller
`timescale 1ns/100ps
module irpwm_checker
  import irpwm_pkg::*;
#(
  parameter int LONG_SD_CYCLES = LONG_SD_CYC,
  parameter int PROG_MAX_CYCLES = PROG_MAX_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire irpwm_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic user_tx,
  input wire logic user_rx_pulse,
  input wire logic mode_long,
  input wire logic prog_error,
  input wire irpwm_pins_t pins,
  input wire logic rx_pin_n
);
  logic [CNT_W-1:0] sd_cnt_reg;
  logic [CNT_W-1:0] tx_cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk)
  begin
    sd_cnt_reg <= (rst || !pins.shutdown_input) ? '0 : sd_cnt_reg + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    tx_cnt_reg <= (rst || !pins.tx_data) ? '0 : tx_cnt_reg + 1'b1;
  end
  sequence s_sd_fall;
    $fell(pins.shutdown_input);
  endsequence
  sequence s_tx_hold;
    $stable(pins.tx_data) [*8] ##16 $stable(pins.tx_data);
  endsequence
  a_setup_time: assert property (
    s_sd_fall |-> $past(pins.shutdown_input, SETUP_CYC)) else $error("setup short");
  a_hold_time: assert property (
    s_sd_fall |-> s_tx_hold) else $error("hold short");
  a_sd_window: assert property (
    s_sd_fall |-> sd_cnt_reg < PROG_MAX_CYCLES || sd_cnt_reg >= LONG_SD_CYCLES)
    else $error("shutdown length");
  a_mode_latch: assert property (
    s_sd_fall |-> mode_long == $past(pins.tx_data)) else $error("mode latch");
  a_long_clear: assert property (
    $fell(pins.shutdown_input) && sd_cnt_reg >= LONG_SD_CYCLES |-> !mode_long)
    else $error("long shutdown");
  a_mode_kept: assert property (
    !$fell(pins.shutdown_input) |-> $stable(mode_long)) else $error("mode moved");
  a_tx_limit: assert property (
    tx_cnt_reg <= TX_MAX_CYC) else $error("tx too long");
  a_rx_quiet: assert property (
    $past(pins.shutdown_input) |-> !user_rx_pulse) else $error("rx while shut down");
  a_tx_follow: assert property (
    cmd_ready && $past(cmd_ready) && !$past(user_tx) |-> !pins.tx_data)
    else $error("tx follow");
endmodule
bind irpwm_host irpwm_checker #(.LONG_SD_CYCLES(LONG_SD_CYCLES),
  .PROG_MAX_CYCLES(PROG_MAX_CYCLES)) u_chk (.clk(clk), .rst(rst), .cmd(cmd),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .user_tx(user_tx),
  .user_rx_pulse(user_rx_pulse), .mode_long(mode_long), .prog_error(prog_error),
  .pins(pins), .rx_pin_n(rx_pin_n));

// [verification/irpwm_dev_model.sv]
// behavioural model of the transceiver behind the host controller
`timescale 1ns/100ps
module irpwm_dev_model
  import irpwm_pkg::*;
#(
  parameter real LONG_NS = 1500000.0
)
(
  input wire irpwm_pins_t pins,
  input wire logic light,
  output logic rx_n,
  output logic mode
);
  realtime t_rise = 0.0;
  logic low = 1'b0;
  initial mode = MODE_SHORT;
  always @(posedge pins.shutdown_input)
    t_rise = $realtime;
  // the first fall comes from the power-up unknown, not from a pulse
  always @(negedge pins.shutdown_input)
    if (t_rise == 0.0)
      mode = MODE_SHORT;
    else if ($realtime - t_rise >= LONG_NS)
      mode = MODE_SHORT;
    else
      mode = pins.tx_data;
  always @(posedge light)
    if (!pins.shutdown_input && !pins.tx_data)
    begin
      low = 1'b1;
      #(mode ? 2000 : 400) low = 1'b0;
    end
  // output floats to the weak pull-up while shut down
  assign rx_n = !(low && !pins.shutdown_input);
endmodule

// [verification/tb_irpwm_host.sv]
// self-checking testbench of the infrared pulse-width mode host controller
`timescale 1ns/100ps
module tb_irpwm_host;
  import irpwm_pkg::*;
  localparam int LSD = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  irpwm_cmd_t cmd = IRPWM_CMD_NONE;
  irpwm_cmd_t c;
  irpwm_cmd_t tab[5] = '{IRPWM_CMD_SET_LONG, IRPWM_CMD_SET_LONG, IRPWM_CMD_SHUTDOWN,
    IRPWM_CMD_SET_LONG, IRPWM_CMD_SET_SHORT};
  logic cmd_valid = 1'b0;
  logic user_tx = 1'b0;
  logic light = 1'b0;
  logic cmd_ready, user_rx_pulse, mode_long, prog_error, rx_pin_n, dev_mode;
  irpwm_pins_t pins;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  integer seed = 56388;
  irpwm_host #(.LONG_SD_CYCLES(LSD), .PROG_MAX_CYCLES(40)) dut (.clk(clk), .rst(rst),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .user_tx(user_tx),
    .user_rx_pulse(user_rx_pulse), .mode_long(mode_long), .prog_error(prog_error),
    .pins(pins), .rx_pin_n(rx_pin_n));
  irpwm_dev_model #(.LONG_NS(LSD * 8)) dev (.pins(pins), .light(light), .rx_n(rx_pin_n),
    .mode(dev_mode));
  initial forever #4 clk = ~clk;
  task automatic end_of_test();
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      chk(1'b0, "timeout");
      end_of_test();
    end
  end
  task automatic send(input irpwm_cmd_t k);
    int i;
    @(negedge clk);
    cmd = k;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 200)
    begin
      @(negedge clk);
      i++;
    end
    chk(cmd_ready, "stuck busy");
  endtask
  // a receive pulse is expected only while not transmitting
  task automatic flash(input logic tx);
    int n;
    n = 0;
    user_tx = tx;
    repeat (3) @(negedge clk);
    light = 1'b1;
    repeat (8)
    begin
      @(negedge clk);
      n += int'(user_rx_pulse === 1'b1);
    end
    light = 1'b0;
    chk(n == int'(!tx), "rx pulse count");
    repeat (260) @(negedge clk);
    user_tx = 1'b0;
  endtask
  function automatic logic exp_mode(input irpwm_cmd_t k);
    return k == IRPWM_CMD_SET_LONG;
  endfunction
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk(mode_long === 1'b0 && pins === 2'b00, "reset state");
    flash(1'b0);
    for (int k = 0; k < 16; k++)
    begin
      c = (k < 5) ? tab[k] : irpwm_cmd_t'(2'(1 + $unsigned($random(seed)) % 3));
      send(c);
      chk(mode_long === exp_mode(c), "host mode");
      chk(dev_mode === exp_mode(c), "device mode");
      flash(1'($random(seed)));
    end
    @(negedge clk);
    user_tx = 1'b1;
    repeat (TX_MAX_CYC - 20) @(negedge clk);
    chk(pins.tx_data === 1'b1, "emitter cut early");
    repeat (40) @(negedge clk);
    chk(pins.tx_data === 1'b0, "emitter not cut");
    user_tx = 1'b0;
    chk(prog_error === 1'b0, "programming overrun");
    end_of_test();
  end
endmodule
